// *** core/adc_flags_pkg.sv ***
// Purpose: shared constants for the converter completion and result block
// Assumes: 32-bit register port, byte offsets on word boundaries
// Notes:   offsets and bit positions are used by the main block and its store
package adc_flags_pkg;
   // ==========================================================
   // register port
   localparam int          ADDR_W          = 8;
   localparam int          BUS_W           = 32;
   localparam logic [7:0]  OFS_NORMAL_CTRL = 8'h00;
   localparam logic [7:0]  OFS_PRIO_CTRL   = 8'h04;
   localparam logic [7:0]  OFS_RESULT_BASE = 8'h08;
   localparam logic [7:0]  OFS_RESULT_LAST = 8'h24;
   localparam logic [7:0]  OFS_PRIO_RESULT = 8'h28;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h2c;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h30;
   // ==========================================================
   // field positions
   localparam int          BIT_REPEAT      = 0;
   localparam int          BIT_SCAN        = 1;
   localparam int          BIT_ITM_LO      = 2;
   localparam int          BIT_EOC         = 4;
   localparam int          BIT_BUSY        = 5;
   localparam int          BIT_EOC_HP      = 0;
   localparam int          BIT_BUSY_HP     = 1;
   localparam int          BIT_OVERRUN     = 16;
   localparam int          IRQ_NORMAL      = 0;
   localparam int          IRQ_PRIO        = 1;
   localparam int          IRQ_BITS        = 2;
   // ==========================================================
   // interval codes and result slots
   localparam logic [1:0]  ITM_EVERY_1     = 2'h0;
   localparam logic [1:0]  ITM_EVERY_4     = 2'h1;
   localparam logic [1:0]  ITM_EVERY_8     = 2'h2;
   localparam int          RESULT_REGS     = 8;
   localparam logic [2:0]  LAST_OF_4       = 3'h3;
   localparam logic [2:0]  LAST_OF_8       = 3'h7;
   localparam logic [3:0]  PRIO_SLOT       = 4'h8;
   localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
   // ==========================================================
   // normal mode, encoded as {scan, repeat}
   typedef enum logic [1:0] {
      FIXED_SINGLE,
      FIXED_REPEAT,
      SCAN_SINGLE,
      SCAN_REPEAT
   } normal_mode_t;
endpackage

// *** core/result_store.sv ***
// Purpose: storage of conversion results with registered read word
// Assumes: one write and one read per cycle
// Notes:   flags live outside; they are merged into the read word here
`timescale 1ns/100ps
`default_nettype none
module result_store #(
   parameter int DATA_W  = 10,
   parameter int ENTRIES = 9
) (
   input  wire logic                       core_clk,
   input  wire logic                       reset_n,
   input  wire logic                       wr_en,
   input  wire logic [3:0]                 wr_idx,
   input  wire logic [DATA_W-1:0]          wr_data,
   input  wire logic                       rd_sel_mem,
   input  wire logic [3:0]                 rd_idx,
   input  wire logic [1:0]                 rd_flags,
   input  wire logic [31:0]                rd_bypass,
   output logic      [31:0]                rd_data
);
   // ==========================================================
   // storage
   logic [DATA_W-1:0] mem [ENTRIES];
   logic [31:0]       next_rd_data;

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // ==========================================================
   // read word, data low and flags at the overrun position
   always_comb begin
      next_rd_data = rd_bypass;
      if (rd_sel_mem) begin
         next_rd_data = 32'(mem[rd_idx]) |
                        (32'(rd_flags) << adc_flags_pkg::BIT_OVERRUN);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= adc_flags_pkg::RESET_WORD;
      end else begin
         rd_data <= next_rd_data;
      end
   end
endmodule
`default_nettype wire

// *** core/adc_completion_flags.sv ***
// Purpose: completion flags, interrupts and result steering of a converter
// Assumes: converter core gives one-cycle done pulses with channel and data
// Notes:   registers reached over a plain strobe port, read data one cycle later
// Function
// - A finished normal conversion sets the normal end flag to 1 for polling.
// - A result is valid when its overrun flag is 0 and its ready flag is 1.
// - Reading the control words clears the normal and priority end flags.
// - Repeat and scan bits 0/0, 1/0, 0/1, 1/1 pick the four normal modes.
// - Fixed single mode raises the interrupt and end flag, busy reads 0 after.
// - Fixed repeat raises them every 1, 4 or 8 results for 00, 01, 10, busy 1.
// - Scan single mode raises them at the end of the scan, busy reads 0 after.
// - Scan repeat mode raises them after each scan and keeps busy at 1.
// - Outside fixed repeat, inputs 0-7 use their slot and 8-11 reuse slots 0-3.
// - Fixed repeat fills slot 0 only, slots 0-3 or slots 0-7 in turn and wraps.
// - A priority completion raises its own interrupt, sets its end flag, clears its busy flag.
// - A priority result always goes to its own dedicated register.
`timescale 1ns/100ps
`default_nettype none
module adc_completion_flags #(
   parameter int DATA_W = 10
) (
   input  wire logic                       core_clk,
   input  wire logic                       reset_n,
   input  wire logic [7:0]                 reg_addr,
   input  wire logic [31:0]                reg_wdata,
   input  wire logic                       reg_write,
   input  wire logic                       reg_read,
   output logic      [31:0]                reg_rdata,
   input  wire logic                       normal_start,
   input  wire logic                       priority_start,
   input  wire logic                       conv_done,
   input  wire logic [3:0]                 analog_input_channel,
   input  wire logic                       conv_scan_last,
   input  wire logic [DATA_W-1:0]          conv_result,
   input  wire logic                       priority_done,
   input  wire logic [DATA_W-1:0]          priority_result,
   output logic                            normal_completion_irq,
   output logic                            priority_completion_irq,
   output logic                            irq
);
   // ==========================================================
   // state
   logic                       repeat_on;
   logic                       scan_on;
   logic [1:0]                 interval;
   logic                       eoc;
   logic                       busy;
   logic                       eoc_hp;
   logic                       busy_hp;
   logic [2:0]                 fill;
   logic [8:0]                 ready;
   logic [8:0]                 overrun;
   logic [1:0]                 irq_status;
   logic [1:0]                 irq_mask;
   logic                       next_repeat_on;
   logic                       next_scan_on;
   logic [1:0]                 next_interval;
   logic                       next_eoc;
   logic                       next_busy;
   logic                       next_eoc_hp;
   logic                       next_busy_hp;
   logic [2:0]                 next_fill;
   logic [8:0]                 next_ready;
   logic [8:0]                 next_overrun;
   logic [1:0]                 next_irq_status;
   logic [1:0]                 next_irq_mask;
   logic                       next_normal_irq;
   logic                       next_priority_irq;
   logic                       next_irq;
   // ==========================================================
   // decode
   adc_flags_pkg::normal_mode_t mode;
   logic                       rd_normal;
   logic                       rd_prio;
   logic                       rd_status;
   logic                       wr_normal;
   logic                       wr_mask;
   logic                       rd_result;
   logic [3:0]                 rd_slot;
   logic [2:0]                 slot;
   logic [2:0]                 last_slot;
   logic                       fill_end;
   logic                       normal_event;
   logic                       busy_clear;
   logic [3:0]                 wr_idx;
   logic [DATA_W-1:0]          wr_data;
   logic                       wr_en;
   logic [31:0]                bypass;
   logic                       sel_mem;
   assign mode      = adc_flags_pkg::normal_mode_t'({scan_on, repeat_on});
   assign rd_normal = reg_read && (reg_addr == adc_flags_pkg::OFS_NORMAL_CTRL);
   assign rd_prio   = reg_read && (reg_addr == adc_flags_pkg::OFS_PRIO_CTRL);
   assign rd_status = reg_read && (reg_addr == adc_flags_pkg::OFS_IRQ_STATUS);
   assign wr_normal = reg_write && (reg_addr == adc_flags_pkg::OFS_NORMAL_CTRL);
   assign wr_mask   = reg_write && (reg_addr == adc_flags_pkg::OFS_IRQ_MASK);
   // result words sit on consecutive word offsets, the priority one last
   assign rd_result = (reg_addr >= adc_flags_pkg::OFS_RESULT_BASE) &&
                      (reg_addr <= adc_flags_pkg::OFS_PRIO_RESULT) &&
                      (reg_addr[1:0] == 2'h0);
   assign rd_slot   = 4'((reg_addr - adc_flags_pkg::OFS_RESULT_BASE) >> 2);
   // ==========================================================
   // steering of normal results
   // reserved interval 11 falls back to every result
   assign last_slot = (interval == adc_flags_pkg::ITM_EVERY_4) ? adc_flags_pkg::LAST_OF_4 :
                      (interval == adc_flags_pkg::ITM_EVERY_8) ? adc_flags_pkg::LAST_OF_8 :
                      3'h0;
   always_comb begin
      // 8-11 wrap onto 0-3 by dropping the top channel bit
      slot     = analog_input_channel[2:0];
      fill_end = 1'b0;
      case (mode)
         adc_flags_pkg::FIXED_REPEAT: begin
            slot     = fill & last_slot;
            fill_end = ((fill & last_slot) == last_slot);
         end
         adc_flags_pkg::SCAN_SINGLE,
         adc_flags_pkg::SCAN_REPEAT: begin
            fill_end = conv_scan_last;
         end
         adc_flags_pkg::FIXED_SINGLE: begin
            fill_end = 1'b1;
         end
         default: begin
            fill_end = 1'b1;
         end
      endcase
   end
   // a stopped repeat ends at the next done; scans end only at the last channel
   assign normal_event = conv_done && fill_end;
   assign busy_clear   = conv_done && !repeat_on && (!scan_on || conv_scan_last);
   always_comb begin
      wr_en   = conv_done || priority_done;
      wr_idx  = {1'b0, slot};
      wr_data = conv_result;
      if (priority_done) begin
         wr_idx  = adc_flags_pkg::PRIO_SLOT;
         wr_data = priority_result;
      end
   end
   // ==========================================================
   // control and flags
   always_comb begin
      next_repeat_on = repeat_on;
      next_scan_on   = scan_on;
      next_interval  = interval;
      next_irq_mask  = irq_mask;
      next_fill      = fill;
      if (wr_normal) begin
         next_repeat_on = reg_wdata[adc_flags_pkg::BIT_REPEAT];
         next_scan_on   = reg_wdata[adc_flags_pkg::BIT_SCAN];
         next_interval  = reg_wdata[adc_flags_pkg::BIT_ITM_LO +: 2];
      end
      if (wr_mask) begin
         next_irq_mask = reg_wdata[adc_flags_pkg::IRQ_BITS-1:0];
      end
      if (normal_start) begin
         next_fill = 3'h0;
      end else if (conv_done && mode == adc_flags_pkg::FIXED_REPEAT) begin
         next_fill = (fill_end) ? 3'h0 : 3'(fill + 3'h1);
      end
   end
   always_comb begin
      // the set is applied after the read clear so an event is never lost
      next_eoc = eoc;
      if (rd_normal) begin
         next_eoc = 1'b0;
      end
      if (normal_event) begin
         next_eoc = 1'b1;
      end
      next_busy = busy;
      if (busy_clear) begin
         next_busy = 1'b0;
      end
      if (normal_start) begin
         next_busy = 1'b1;
      end
      next_eoc_hp = eoc_hp;
      if (rd_prio) begin
         next_eoc_hp = 1'b0;
      end
      if (priority_done) begin
         next_eoc_hp = 1'b1;
      end
      next_busy_hp = busy_hp;
      if (priority_done) begin
         next_busy_hp = 1'b0;
      end
      if (priority_start) begin
         next_busy_hp = 1'b1;
      end
   end
   always_comb begin
      // a read of a result word retires it; a fresh store wins over that
      next_ready   = ready;
      next_overrun = overrun;
      if (reg_read && rd_result) begin
         next_ready[rd_slot]   = 1'b0;
         next_overrun[rd_slot] = 1'b0;
      end
      if (wr_en) begin
         next_ready[wr_idx] = 1'b1;
         if (ready[wr_idx]) begin
            next_overrun[wr_idx] = 1'b1;
         end
      end
   end
   always_comb begin
      next_irq_status = irq_status;
      if (rd_status) begin
         next_irq_status = 2'h0;
      end
      if (normal_event) begin
         next_irq_status[adc_flags_pkg::IRQ_NORMAL] = 1'b1;
      end
      if (priority_done) begin
         next_irq_status[adc_flags_pkg::IRQ_PRIO] = 1'b1;
      end
      next_normal_irq   = normal_event;
      next_priority_irq = priority_done;
      next_irq          = |(next_irq_status & next_irq_mask);
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         repeat_on               <= 1'b0;
         scan_on                 <= 1'b0;
         interval                <= adc_flags_pkg::ITM_EVERY_1;
         eoc                     <= 1'b0;
         busy                    <= 1'b0;
         eoc_hp                  <= 1'b0;
         busy_hp                 <= 1'b0;
         fill                    <= 3'h0;
         ready                   <= 9'h000;
         overrun                 <= 9'h000;
         irq_status              <= 2'h0;
         irq_mask                <= 2'h0;
         normal_completion_irq   <= 1'b0;
         priority_completion_irq <= 1'b0;
         irq                     <= 1'b0;
      end else begin
         repeat_on               <= next_repeat_on;
         scan_on                 <= next_scan_on;
         interval                <= next_interval;
         eoc                     <= next_eoc;
         busy                    <= next_busy;
         eoc_hp                  <= next_eoc_hp;
         busy_hp                 <= next_busy_hp;
         fill                    <= next_fill;
         ready                   <= next_ready;
         overrun                 <= next_overrun;
         irq_status              <= next_irq_status;
         irq_mask                <= next_irq_mask;
         normal_completion_irq   <= next_normal_irq;
         priority_completion_irq <= next_priority_irq;
         irq                     <= next_irq;
      end
   end
   // ==========================================================
   // read word
   always_comb begin
      bypass  = adc_flags_pkg::RESET_WORD;
      sel_mem = 1'b0;
      if (reg_read) begin
         case (reg_addr)
            adc_flags_pkg::OFS_NORMAL_CTRL: begin
               bypass[adc_flags_pkg::BIT_REPEAT]        = repeat_on;
               bypass[adc_flags_pkg::BIT_SCAN]          = scan_on;
               bypass[adc_flags_pkg::BIT_ITM_LO +: 2]   = interval;
               bypass[adc_flags_pkg::BIT_EOC]           = eoc;
               bypass[adc_flags_pkg::BIT_BUSY]          = busy;
            end
            adc_flags_pkg::OFS_PRIO_CTRL: begin
               bypass[adc_flags_pkg::BIT_EOC_HP]        = eoc_hp;
               bypass[adc_flags_pkg::BIT_BUSY_HP]       = busy_hp;
            end
            adc_flags_pkg::OFS_IRQ_STATUS: begin
               bypass[adc_flags_pkg::IRQ_BITS-1:0]      = irq_status;
            end
            adc_flags_pkg::OFS_IRQ_MASK: begin
               bypass[adc_flags_pkg::IRQ_BITS-1:0]      = irq_mask;
            end
            default: begin
               sel_mem = rd_result;
            end
         endcase
      end
   end
   result_store #(
      .DATA_W  (DATA_W),
      .ENTRIES (adc_flags_pkg::RESULT_REGS + 1)
   ) u_store (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .wr_en      (wr_en),
      .wr_idx     (wr_idx),
      .wr_data    (wr_data),
      .rd_sel_mem (sel_mem),
      .rd_idx     (rd_slot),
      .rd_flags   ({ready[rd_slot], overrun[rd_slot]}),
      .rd_bypass  (bypass),
      .rd_data    (reg_rdata)
   );
   // ==========================================================
   // checks
   sequence s_single_done;
      conv_done && mode == adc_flags_pkg::FIXED_SINGLE && !normal_start;
   endsequence
   sequence s_flag_up;
      eoc && !busy;
   endsequence
   property p_poll_flag;
      @(posedge core_clk) disable iff (!reset_n)
      normal_event |=> eoc;
   endproperty
   a_poll_flag: assert property (p_poll_flag) else $error("end flag not set");
   property p_valid_pair;
      @(posedge core_clk) disable iff (!reset_n)
      (wr_en && !ready[wr_idx]) |=> (ready[$past(wr_idx)] && !overrun[$past(wr_idx)]);
   endproperty
   a_valid_pair: assert property (p_valid_pair) else $error("bad valid flags");
   property p_read_clears;
      @(posedge core_clk) disable iff (!reset_n)
      (rd_normal && !normal_event) |=> !eoc;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("end flag kept");
   property p_single;
      @(posedge core_clk) disable iff (!reset_n)
      s_single_done |=> s_flag_up ##0 normal_completion_irq;
   endproperty
   a_single: assert property (p_single) else $error("single end wrong");
   property p_repeat_busy;
      @(posedge core_clk) disable iff (!reset_n)
      (busy && repeat_on && !wr_normal) |=> busy;
   endproperty
   a_repeat_busy: assert property (p_repeat_busy) else $error("busy dropped");
   property p_every_four;
      @(posedge core_clk) disable iff (!reset_n)
      (conv_done && mode == adc_flags_pkg::FIXED_REPEAT &&
       interval == adc_flags_pkg::ITM_EVERY_4) |-> (normal_event == (fill[1:0] == 2'h3));
   endproperty
   a_every_four: assert property (p_every_four) else $error("interval wrong");
   property p_scan_single;
      @(posedge core_clk) disable iff (!reset_n)
      (conv_done && mode == adc_flags_pkg::SCAN_SINGLE && conv_scan_last && !normal_start)
      |=> s_flag_up;
   endproperty
   a_scan_single: assert property (p_scan_single) else $error("scan end wrong");
   property p_slot_map;
      @(posedge core_clk) disable iff (!reset_n)
      (conv_done && !priority_done && mode != adc_flags_pkg::FIXED_REPEAT)
      |-> wr_idx[2:0] == analog_input_channel[2:0];
   endproperty
   a_slot_map: assert property (p_slot_map) else $error("slot wrong");
   property p_prio_end;
      @(posedge core_clk) disable iff (!reset_n)
      (priority_done && !priority_start) |=> (eoc_hp && !busy_hp && priority_completion_irq
                                              && ready[adc_flags_pkg::PRIO_SLOT]);
   endproperty
   a_prio_end: assert property (p_prio_end) else $error("priority end wrong");
   property p_irq_level;
      @(posedge core_clk) disable iff (!reset_n)
      ##1 irq == |(irq_status & irq_mask);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
endmodule
`default_nettype wire

// *** dv/adc_completion_flags_tb_top.sv ***
// Purpose: self-checking bench for the completion flags and result steering block
// Assumes: default DATA_W of 10, converter events driven straight from the bench
// Notes:   drivers queue expected words, a monitor pops them as results appear
`timescale 1ns/100ps
`default_nettype none
module adc_completion_flags_tb_top;
   // ==========================================================
   // stimulus and observation
   logic        core_clk                = 1'b0;
   logic        reset_n                 = 1'b0;
   logic [7:0]  reg_addr                = 8'h00;
   logic [31:0] reg_wdata               = 32'h0000_0000;
   logic        reg_write               = 1'b0;
   logic        reg_read                = 1'b0;
   logic [31:0] reg_rdata;
   logic        normal_start            = 1'b0;
   logic        priority_start          = 1'b0;
   logic        conv_done               = 1'b0;
   logic [3:0]  analog_input_channel    = 4'h0;
   logic        conv_scan_last          = 1'b0;
   logic [9:0]  conv_result             = 10'h000;
   logic        priority_done           = 1'b0;
   logic [9:0]  priority_result         = 10'h000;
   logic        normal_completion_irq;
   logic        priority_completion_irq;
   logic        irq;
   int          fail_count              = 0;
   int          check_count             = 0;
   logic [31:0] rd_q[$];
   logic [2:0]  ev_q[$];
   logic        rd_pend                 = 1'b0;
   logic        ev_pend                 = 1'b0;
   logic [1:0]  st                      = 2'h0;
   logic [1:0]  mk                      = 2'h0;
   logic [9:0]  dv[0:8];
   int          n;

   always #10 core_clk = ~core_clk;

   adc_completion_flags dut (
      .core_clk                (core_clk),
      .reset_n                 (reset_n),
      .reg_addr                (reg_addr),
      .reg_wdata               (reg_wdata),
      .reg_write               (reg_write),
      .reg_read                (reg_read),
      .reg_rdata               (reg_rdata),
      .normal_start            (normal_start),
      .priority_start          (priority_start),
      .conv_done               (conv_done),
      .analog_input_channel    (analog_input_channel),
      .conv_scan_last          (conv_scan_last),
      .conv_result             (conv_result),
      .priority_done           (priority_done),
      .priority_result         (priority_result),
      .normal_completion_irq   (normal_completion_irq),
      .priority_completion_irq (priority_completion_irq),
      .irq                     (irq)
   );

   // ==========================================================
   // checking
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // pulses must be absent in every cycle that follows no event
   always @(posedge core_clk) begin
      if (rd_pend)
         chk(reg_rdata, rd_q.pop_front());
      if (ev_pend)
         chk({29'h0, irq, normal_completion_irq, priority_completion_irq},
             {29'h0, ev_q.pop_front()});
      else
         chk({30'h0, normal_completion_irq, priority_completion_irq}, 32'h0);
      rd_pend <= reg_read;
      ev_pend <= conv_done | priority_done;
   end

   // ==========================================================
   // drivers
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      @(posedge core_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_read <= 1'b0;
   endtask

   task pulse_start(input logic hp);
      @(posedge core_clk);
      if (hp)
         priority_start <= 1'b1;
      else
         normal_start <= 1'b1;
      @(posedge core_clk);
      priority_start <= 1'b0;
      normal_start   <= 1'b0;
   endtask

   task conv(input logic [3:0] ch, input logic last, input logic fire, input int k);
      dv[k] = 10'($urandom);
      @(posedge core_clk);
      conv_done            <= 1'b1;
      analog_input_channel <= ch;
      conv_scan_last       <= last;
      conv_result          <= dv[k];
      if (fire)
         st[0] = 1'b1;
      ev_q.push_back({|(st & mk), fire, 1'b0});
      @(posedge core_clk);
      conv_done <= 1'b0;
   endtask

   task rd_status;
      rd(8'h2c, {30'h0, st});
      st = 2'h0;
   endtask

   // repeat bit cleared: the next completion ends the run
   task stop_repeat;
      wr(8'h00, 32'h0);
      conv(4'h0, 1'b0, 1'b1, 0);
      rd(8'h00, 32'h10);
      rd(8'h08, 32'h20000 | dv[0]);
      rd_status;
   endtask

   // ==========================================================
   // scenarios
   initial begin
      void'($urandom(32'h25358104));
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(8'h00, 32'h0);
      rd(8'h3c, 32'h0);
      wr(8'h30, 32'h1);
      mk = 2'h1;
      wr(8'h00, 32'h0);
      pulse_start(1'b0);
      conv(4'h9, 1'b0, 1'b1, 0);
      rd(8'h00, 32'h10);
      rd(8'h00, 32'h0);
      rd(8'h0c, 32'h20000 | dv[0]);
      rd(8'h0c, 32'(dv[0]));
      rd_status;
      for (int i = 0; i < 3; i++) begin
         n = (i == 0) ? 1 : (i == 1) ? 4 : 8;
         wr(8'h00, 32'(i << 2) | 32'h1);
         pulse_start(1'b0);
         for (int k = 0; k <= n; k++)
            conv(4'(k), 1'b0, ((k + 1) % n) == 0, k);
         rd(8'h00, 32'h31 | 32'(i << 2));
         rd(8'h08, 32'h30000 | dv[n]);
         for (int k = 1; k < n; k++)
            rd(8'(8 + 4 * k), 32'h20000 | dv[k]);
         rd_status;
      end
      stop_repeat;
      for (int r = 0; r < 2; r++) begin
         wr(8'h00, 32'h2 | 32'(r));
         pulse_start(1'b0);
         for (int k = 0; k < 4; k++)
            conv(4'(k + 8), k == 3, k == 3, k);
         rd(8'h00, 32'h12 | 32'(r) | 32'(r << 5));
         for (int k = 0; k < 4; k++)
            rd(8'(8 + 4 * k), 32'h20000 | dv[k]);
         rd_status;
      end
      stop_repeat;
      wr(8'h04, 32'hffff_ffff);
      pulse_start(1'b1);
      rd(8'h04, 32'h2);
      dv[8] = 10'($urandom);
      @(posedge core_clk);
      priority_done        <= 1'b1;
      priority_result      <= dv[8];
      analog_input_channel <= 4'h5;
      st[1] = 1'b1;
      ev_q.push_back({|(st & mk), 1'b0, 1'b1});
      @(posedge core_clk);
      priority_done <= 1'b0;
      rd(8'h04, 32'h1);
      rd(8'h04, 32'h0);
      rd(8'h28, 32'h20000 | dv[8]);
      rd_status;
      repeat (4) @(posedge core_clk);
      end_of_test;
   end

   // whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test;
   end
endmodule
`default_nettype wire
